/* File: core/dps_defs.svh */
// Timing counts, widths and reset values for the burst dual-port memory.
`ifndef DPS_DEFS_SVH
`define DPS_DEFS_SVH
`define DPS_ADDR_W           6
`define DPS_DATA_W           16
`define DPS_COUNTER_RST      6'h00
`define DPS_CLK_PERIOD_NS    20
`define DPS_FWD_DELAY_NS     30
`define DPS_CCS_NS           9
`define DPS_FWD_CYCLES       ((`DPS_FWD_DELAY_NS + `DPS_CLK_PERIOD_NS - 1) / `DPS_CLK_PERIOD_NS)
`endif

/* File: core/dps_pkg.sv */
// Types shared by the dual-port memory files.
package dps_pkg;
   typedef struct packed {
      logic       sel_n;
      logic       sel;
      logic       we_n;
      logic       address_strobe_n;
      logic       adv_n;
      logic       clr_n;
      logic [1:0] lane_n;
      logic       pipe;
   } dps_ctrl_type;
   typedef enum logic [1:0] {DPS_IDLE, DPS_READ, DPS_WRITE} dps_op_type;
endpackage

/* File: core/dps_port.sv */
// One port: pin sampling, burst counter, access decode and output stage.
`timescale 1ns/1ps
`include "dps_defs.svh"
module dps_port #(
   parameter int AW = `DPS_ADDR_W,
   parameter int DW = `DPS_DATA_W
) (
   // Clock and reset.
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // Link clock and pins, not yet synchronised.
   input  wire logic                  link_clk,
   input  wire dps_pkg::dps_ctrl_type ctrl_pin,
   input  wire logic [AW-1:0]         addr_pin,
   input  wire logic [DW-1:0]         din_pin,
   input  wire logic                  oe_n_pin,
   // Memory access.
   output logic                       acc_en,
   output logic                       acc_we,
   output logic [1:0]                 acc_lane,
   output logic [AW-1:0]              acc_addr,
   output logic [DW-1:0]              acc_wdata,
   input  wire logic [DW-1:0]         acc_rdata,
   // Data pins and burst address.
   output logic [DW-1:0]              dout,
   output logic [DW-1:0]              dout_oe,
   output logic [AW-1:0]              burst_addr
);
   localparam int CW = $bits(dps_pkg::dps_ctrl_type);
   // Two-stage synchronisers; stage one is read only by stage two.
   logic [CW+AW+DW:0]   s1_ff, s2_ff;
   logic                clk_s1_ff, clk_s2_ff, clk_s3_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff     <= '0;
         s2_ff     <= '0;
         clk_s1_ff <= 1'b0;
         clk_s2_ff <= 1'b0;
         clk_s3_ff <= 1'b0;
      end else begin
         s1_ff     <= {ctrl_pin, addr_pin, din_pin, oe_n_pin};
         s2_ff     <= s1_ff;
         clk_s1_ff <= link_clk;
         clk_s2_ff <= clk_s1_ff;
         clk_s3_ff <= clk_s2_ff;
      end
   end
   // Inputs are held by the host around the link edge, so the delayed copy is stable.
   dps_pkg::dps_ctrl_type ctl;
   logic [AW-1:0]         ad;
   logic [DW-1:0]         di;
   logic                  oe_n, edge_p, selected;
   assign {ctl, ad, di, oe_n} = s2_ff;
   assign edge_p   = clk_s2_ff & ~clk_s3_ff;
   assign selected = ~ctl.sel_n & ctl.sel;
   // Burst counter, independent of chip selects.
   logic [AW-1:0] cnt_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= `DPS_COUNTER_RST;
      end else if (edge_p) begin
         if (!ctl.clr_n) begin
            cnt_ff <= `DPS_COUNTER_RST;
         end else if (!ctl.address_strobe_n) begin
            cnt_ff <= ad;
         end else if (!ctl.adv_n) begin
            cnt_ff <= cnt_ff + 1'b1;
         end
      end
   end
   assign burst_addr = cnt_ff;
   // Access address: pins on strobe, otherwise the counter's next value.
   always_comb begin
      if (!ctl.clr_n) begin
         acc_addr = '0;
      end else if (!ctl.address_strobe_n) begin
         acc_addr = ad;
      end else if (!ctl.adv_n) begin
         acc_addr = cnt_ff + 1'b1;
      end else begin
         acc_addr = cnt_ff;
      end
   end
   assign acc_en    = edge_p & selected;
   assign acc_we    = ~ctl.we_n;
   assign acc_lane  = ~ctl.lane_n;
   assign acc_wdata = di;
   // Flow stage captures at the access; pipe stage delays it one link cycle.
   logic [DW-1:0] flow_ff, pipe_ff;
   logic [1:0]    flow_lane_ff, pipe_lane_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flow_ff      <= '0;
         pipe_ff      <= '0;
         flow_lane_ff <= 2'h0;
         pipe_lane_ff <= 2'h0;
      end else if (edge_p) begin
         flow_ff      <= acc_rdata;
         flow_lane_ff <= (selected & ctl.we_n) ? ~ctl.lane_n : 2'h0;
         pipe_ff      <= flow_ff;
         pipe_lane_ff <= flow_lane_ff;
      end
   end
   // Output enable gates lanes combinationally.
   logic [1:0] lanes;
   assign lanes   = (ctl.pipe ? pipe_lane_ff : flow_lane_ff) & {2{~oe_n}};
   assign dout    = ctl.pipe ? pipe_ff : flow_ff;
   assign dout_oe = {{(DW/2){lanes[1]}}, {(DW/2){lanes[0]}}};
endmodule

/* File: core/dps_top.sv */
// Dual-port synchronous memory with per-port burst counters.
`timescale 1ns/1ps
`include "dps_defs.svh"
// How it works
// - Output enable and mode asynchronous; others sampled on edge.
// - Deselect floats outputs from next edge.
// - Pipelined select changes act one clock later.
// - Pipelined output follows previous cycle controls.
// - Pipelined read data one cycle after flow.
// - Strobe low accepts new address each cycle.
// - Strobe low uses pins, else counter.
// - Clear input zeroes counter, highest priority.
// - Strobe low loads counter from pins.
// - Advance high holds counter, same location.
// - Advance low increments counter by one.
// - Counter ignores chip selects.
// - Cross-port write visible to other port.
// - Read/write low writes, high reads.
// - Lane selects gate writes and read drivers.
// - Mode low flow-through, high pipelined.
// - Counter wraps to zero past top.
module dps_top #(
   parameter int AW = `DPS_ADDR_W,
   parameter int DW = `DPS_DATA_W
) (
   // Clock and reset.
   input  wire logic                  CLK,
   input  wire logic                  RESET_N,
   // Left port pins.
   input  wire logic                  LEFT_PORT_CLOCK,
   input  wire dps_pkg::dps_ctrl_type L_CTRL,
   input  wire logic [AW-1:0]         L_ADDR,
   input  wire logic [DW-1:0]         L_DATA_IN,
   input  wire logic                  L_OE_N,
   output logic [DW-1:0]              L_DATA_OUT,
   output logic [DW-1:0]              L_DATA_OE,
   output logic [AW-1:0]              L_BURST_ADDR,
   // Right port pins.
   input  wire logic                  RIGHT_PORT_CLOCK,
   input  wire dps_pkg::dps_ctrl_type R_CTRL,
   input  wire logic [AW-1:0]         R_ADDR,
   input  wire logic [DW-1:0]         R_DATA_IN,
   input  wire logic                  R_OE_N,
   output logic [DW-1:0]              R_DATA_OUT,
   output logic [DW-1:0]              R_DATA_OE,
   output logic [AW-1:0]              R_BURST_ADDR
);
   // ----------------------------------------
   // Reset release.
   // ----------------------------------------
   logic rst_a_ff, rst_b_ff;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_a_ff <= 1'b0;
         rst_b_ff <= 1'b0;
      end else begin
         rst_a_ff <= 1'b1;
         rst_b_ff <= rst_a_ff;
      end
   end
   // ----------------------------------------
   // Ports.
   // ----------------------------------------
   logic          l_en, r_en, l_we, r_we;
   logic [1:0]    l_lane, r_lane;
   logic [AW-1:0] l_addr, r_addr;
   logic [DW-1:0] l_wd, r_wd, l_rd, r_rd;
   // Each port has its own counter and output stage.
   dps_port #(.AW(AW), .DW(DW)) u_left (
      .clk        (CLK),
      .rst_n      (rst_b_ff),
      .link_clk   (LEFT_PORT_CLOCK),
      .ctrl_pin   (L_CTRL),
      .addr_pin   (L_ADDR),
      .din_pin    (L_DATA_IN),
      .oe_n_pin   (L_OE_N),
      .acc_en     (l_en),
      .acc_we     (l_we),
      .acc_lane   (l_lane),
      .acc_addr   (l_addr),
      .acc_wdata  (l_wd),
      .acc_rdata  (l_rd),
      .dout       (L_DATA_OUT),
      .dout_oe    (L_DATA_OE),
      .burst_addr (L_BURST_ADDR)
   );
   dps_port #(.AW(AW), .DW(DW)) u_right (
      .clk        (CLK),
      .rst_n      (rst_b_ff),
      .link_clk   (RIGHT_PORT_CLOCK),
      .ctrl_pin   (R_CTRL),
      .addr_pin   (R_ADDR),
      .din_pin    (R_DATA_IN),
      .oe_n_pin   (R_OE_N),
      .acc_en     (r_en),
      .acc_we     (r_we),
      .acc_lane   (r_lane),
      .acc_addr   (r_addr),
      .acc_wdata  (r_wd),
      .acc_rdata  (r_rd),
      .dout       (R_DATA_OUT),
      .dout_oe    (R_DATA_OE),
      .burst_addr (R_BURST_ADDR)
   );
   // ----------------------------------------
   // Array.
   // ----------------------------------------
   // Storage is not reset; contents are undefined at power-up like a real array.
   // Left write is applied after right, so a same-word collision keeps left: undefined by design.
   // Each lane owns its own array, so no storage element is written by two processes.
   genvar g;
   for (g = 0; g < 2; g++) begin : g_lane
      logic [DW/2-1:0] lane_ff [0:(1<<AW)-1];
      always_ff @(posedge CLK) begin
         if (r_en && r_we && r_lane[g]) begin
            lane_ff[r_addr] <= r_wd[g*(DW/2) +: DW/2];
         end
         if (l_en && l_we && l_lane[g]) begin
            lane_ff[l_addr] <= l_wd[g*(DW/2) +: DW/2];
         end
      end
   end
   // Reads see the stored word; a write one CLK earlier is visible, well inside 30 ns.
   assign l_rd = {g_lane[1].lane_ff[l_addr], g_lane[0].lane_ff[l_addr]};
   assign r_rd = {g_lane[1].lane_ff[r_addr], g_lane[0].lane_ff[r_addr]};
endmodule

/* File: bench/dps_top_properties.sv */
// Pin-level assertions for the left port of the dual-port memory top.
`timescale 1ns/1ps
module dps_top_properties #(parameter int AW = 6, parameter int DW = 16) (
   // Clock and reset.
   input wire logic                  CLK,
   input wire logic                  RESET_N,
   // Left port pins.
   input wire dps_pkg::dps_ctrl_type L_CTRL,
   input wire logic [AW-1:0]         L_ADDR,
   input wire logic                  L_OE_N,
   input wire logic [DW-1:0]         L_DATA_OE,
   input wire logic [AW-1:0]         L_BURST_ADDR
);
   // Bounds are in system clocks, since every port edge is synchronised first.
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   chk_oe_floats: assert property (L_OE_N [*4] |-> L_DATA_OE == '0)
      else $error("driving with output enable high");
   chk_deselect_float: assert property (
      (L_CTRL.sel_n && !L_CTRL.pipe) [*8] |-> ##[0:8] L_DATA_OE == '0) else $error("no float");
   chk_pipe_deselect: assert property (
      (L_CTRL.pipe && L_CTRL.sel_n) [*8] ##1 L_CTRL.sel_n [*8] |-> ##[0:4] L_DATA_OE == '0)
      else $error("pipelined deselect late");
   chk_write_float: assert property (
      (!L_CTRL.we_n && !L_CTRL.pipe) [*8] |-> ##[0:8] L_DATA_OE == '0) else $error("write drove");
   chk_clear_zero: assert property (
      !L_CTRL.clr_n [*8] |-> ##[0:8] L_BURST_ADDR == '0) else $error("counter not cleared");
   chk_load_addr: assert property (
      (!L_CTRL.address_strobe_n && L_CTRL.clr_n) [*8] |-> ##4 L_BURST_ADDR == $past(L_ADDR, 4))
      else $error("counter not loaded");
   chk_hold_addr: assert property (
      (L_CTRL.address_strobe_n && L_CTRL.adv_n && L_CTRL.clr_n) [*6] |-> $stable(L_BURST_ADDR))
      else $error("counter moved on hold");
   chk_count_step: assert property (
      (L_CTRL.address_strobe_n && L_CTRL.clr_n) [*6] ##0 $changed(L_BURST_ADDR)
      |-> L_BURST_ADDR == $past(L_BURST_ADDR) + 1'b1) else $error("counter step wrong");
endmodule
bind dps_top dps_top_properties #(.AW(AW), .DW(DW)) u_props (.CLK, .RESET_N, .L_CTRL,
   .L_ADDR, .L_OE_N, .L_DATA_OE, .L_BURST_ADDR);

/* File: bench/dps_host.sv */
// Host model for one port: makes the port clock and drives the port pins.
`timescale 1ns/1ps
module dps_host #(parameter real PHASE = 7.0) (
   // Request from the bench.
   input wire logic                  req_valid,
   input wire dps_pkg::dps_ctrl_type req_ctrl,
   input wire logic [5:0]            req_addr,
   input wire logic [15:0]           req_data,
   // Port pins.
   output logic                      pclk,
   output dps_pkg::dps_ctrl_type     ctrl,
   output logic [5:0]                addr,
   output logic [15:0]               data
);
   // Free-running 160 ns clock; pins start idle so early edges do nothing.
   initial begin
      pclk = 1'b0;
      ctrl = 9'h17e;
      addr = 6'h00;
      data = 16'h0000;
      #(PHASE);
      forever #80 pclk = ~pclk;
   end
   // Pins move on the falling edge, half a period clear of the sampling edge.
   // Between requests the port is deselected and the counter held, so a word is
   // only read after the host wrote it; a pipelined check leans on the idle edge after it.
   always @(negedge pclk) begin
      ctrl <= req_valid ? req_ctrl : 9'h17e | {8'h00, req_ctrl.pipe};
      addr <= req_valid ? req_addr : ~addr;
      data <= req_valid ? req_data : ~data;
   end
endmodule

/* File: bench/tb_dual_port_sram_burst_port.sv */
// Self-checking bench for the dual-port memory with a model of both ports.
`timescale 1ns/1ps
module tb_dual_port_sram_burst_port;
   logic                  clk = 1'b0;
   logic                  reset_n = 1'b0;
   logic [1:0]            pclk;
   logic [1:0]            vld = 2'h0;
   logic [1:0]            oe_n = 2'h0;
   dps_pkg::dps_ctrl_type rc [2] = '{9'h17e, 9'h17e};
   dps_pkg::dps_ctrl_type pc [2];
   logic [5:0]            ra [2], pa [2], ba [2];
   logic [15:0]           rd [2], pd [2], dout [2], doe [2];
   logic [31:0]           r;
   int                    failures = 0;
   int                    tests_run = 0;
   int                    cycles = 0;
   int                    seed = 32'hcbbe7a58;
   int                    cnt [2] = '{0, 0};
   int                    mem [64];
   dps_host #(.PHASE(7.0)) u_hl (.req_valid(vld[0]), .req_ctrl(rc[0]), .req_addr(ra[0]),
      .req_data(rd[0]), .pclk(pclk[0]), .ctrl(pc[0]), .addr(pa[0]), .data(pd[0]));
   dps_host #(.PHASE(53.0)) u_hr (.req_valid(vld[1]), .req_ctrl(rc[1]), .req_addr(ra[1]),
      .req_data(rd[1]), .pclk(pclk[1]), .ctrl(pc[1]), .addr(pa[1]), .data(pd[1]));
   dps_top dut_u (.CLK(clk), .RESET_N(reset_n), .LEFT_PORT_CLOCK(pclk[0]), .L_CTRL(pc[0]),
      .L_ADDR(pa[0]), .L_DATA_IN(pd[0]), .L_OE_N(oe_n[0]), .L_DATA_OUT(dout[0]),
      .L_DATA_OE(doe[0]), .L_BURST_ADDR(ba[0]), .RIGHT_PORT_CLOCK(pclk[1]), .R_CTRL(pc[1]),
      .R_ADDR(pa[1]), .R_DATA_IN(pd[1]), .R_OE_N(oe_n[1]), .R_DATA_OUT(dout[1]),
      .R_DATA_OE(doe[1]), .R_BURST_ADDR(ba[1]));
   always #10 clk = ~clk;
   // The run needs a few thousand cycles; the ceiling leaves ample slack.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 12000) begin
         failures++;
         end_sim();
      end
   end
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // One access: request, model update at the taking edge, check before the next edge.
   task automatic op(int p, dps_pkg::dps_ctrl_type c, logic [5:0] a, logic [15:0] d, logic o);
      logic [15:0] m;
      logic [15:0] e;
      @(posedge pclk[p]);
      #1;
      rc[p] = c;
      ra[p] = a;
      rd[p] = d;
      oe_n[p] = o;
      vld[p] = 1'b1;
      @(negedge pclk[p]);
      #1 vld[p] = 1'b0;
      @(posedge pclk[p]);
      cnt[p] = !c.clr_n ? 0 : !c.address_strobe_n ? int'(a)
             : !c.adv_n ? (cnt[p] + 1) % 64 : cnt[p];
      m = {{8{!c.lane_n[1]}}, {8{!c.lane_n[0]}}};
      if (!c.sel_n && c.sel && !c.we_n) mem[cnt[p]] = (mem[cnt[p]] & ~int'(m)) | int'(d & m);
      e = (!c.sel_n && c.sel && c.we_n && !o) ? m : 16'h0000;
      if (c.pipe) @(posedge pclk[p]);
      #140;
      check("burst address", {10'h000, ba[p]}, 16'(cnt[p]));
      check("drive enable", doe[p], e);
      check("read data", dout[p] & e, 16'(mem[cnt[p]]) & e);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (10) @(posedge clk);
      for (int i = 0; i <= 64; i++) begin
         r = $random(seed);
         op(0, {5'b01010, i != 0, 3'b000}, r[5:0], r[15:0], 1'b0);
      end
      $display("test burst fill done");
      for (int p = 0; p < 2; p++) begin
         r = $random(seed);
         op(p, 9'h098, r[5:0], r[31:16], 1'b0);
         op(1 - p, 9'h0d8, r[5:0], r[15:0], 1'b0);
      end
      $display("test cross port done");
      for (int m = 0; m < 2; m++) begin
         for (int k = 0; k < 60; k++) begin
            r = $random(seed);
            op(int'(r[15]), {r[8] & r[10], r[7] | r[11], r[6:4], r[3] | r[9], r[2:1], m[0]},
               r[17:12], r[31:16], r[13] & r[14]);
         end
         $display("test random mode %0d done", m);
      end
      end_sim();
   end
endmodule
